// file: clock_control_map.vh
// Register map, field positions and timing counts of the clock control block
// Operation
// - Slow clock stop bit set halts the slow clock in Stop mode; resets to 1
// - Peripheral clock stop bit gates UART and timer clocks in Idle; resets 0
// - Fast clock stop bit halts the fast source in Slow or Idle mode; resets 0
// - Fast clock stop bit is writable only while running from the slow clock
// - Source select: 0 picks slow clock, 1 picks fast clock; resets to 0
// - Source select is writable only while the fast clock stop bit is 0
// - Prescaler 00 divides by 16, 01 by 4, 10 by 2, 11 by 1; resets 11
// - A new prescaler ratio takes effect within 16 source clock cycles
`ifndef CLOCK_CONTROL_MAP_VH
`define CLOCK_CONTROL_MAP_VH

// Register addresses
`define CLK_CTRL_ADDR 8'hd8
`define CLK_STATUS_ADDR 8'hd7

// Control register fields
`define SLOW_STOP_BIT 5
`define PERIPH_STOP_BIT 4
`define FAST_STOP_BIT 3
`define SOURCE_SEL_BIT 2
`define PRESCALE_HI 1
`define PRESCALE_LO 0

// Reset values
`define SLOW_STOP_RST 1'b1
`define PERIPH_STOP_RST 1'b0
`define FAST_STOP_RST 1'b0
`define SOURCE_SEL_RST 1'b0
`define PRESCALE_RST 2'h3

// Prescaler codes
`define PSC_DIV16 2'h0
`define PSC_DIV4 2'h1
`define PSC_DIV2 2'h2
`define PSC_DIV1 2'h3

// Longest delay, in source cycles, before a new ratio applies
`define PRESCALE_MAX_DELAY 16

`endif

// file: prescale_divider.v
// Source clock prescaler producing a glitch-free system clock tick
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_map.vh"

module prescale_divider #(
    parameter CNT_W = 4
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire src_tick_i,
    input wire [1:0] ratio_i,
    output wire wrap_o,
    output reg tick_o,
    output reg [1:0] ratio_o
);

    reg [CNT_W-1:0] cnt_q;

    // Last count value of one output period for a prescaler code
    function [CNT_W-1:0] last_count;
        input [1:0] code;
        begin
            case (code)
                `PSC_DIV16: last_count = 4'hf;
                `PSC_DIV4: last_count = 4'h3;
                `PSC_DIV2: last_count = 4'h1;
                default: last_count = 4'h0;
            endcase
        end
    endfunction

    // Period boundary: last source tick of the current output period
    assign wrap_o = src_tick_i & (cnt_q == last_count(ratio_o));

    // Count source ticks, take the new ratio only at a period boundary
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            cnt_q <= {CNT_W{1'b0}};
            tick_o <= 1'b0;
            ratio_o <= `PRESCALE_RST;
        end
        else if (ce_i)
        begin
            tick_o <= wrap_o;
            if (wrap_o)
            begin
                cnt_q <= {CNT_W{1'b0}};
                ratio_o <= ratio_i;
            end
            else if (src_tick_i)
            begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // prescale_divider

`default_nettype wire

// file: system_clock_select_gating.v
// Clock source select, prescaler and clock gating with its control register
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_map.vh"

module system_clock_select_gating #(
    parameter CNT_W = 4
) (
    input wire clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire stop_mode_i,
    input wire idle_mode_i,
    input wire slow_tick_i,
    input wire fast_tick_i,
    output reg slow_osc_en_o,
    output reg fast_osc_en_o,
    output reg periph_clk_en_o,
    output wire sys_tick_o,
    output wire cpu_tick_o,
    output wire periph_tick_o,
    output reg active_source_o
);

    // Source switch states
    localparam ST_RUN = 1'b0;
    localparam ST_DRAIN = 1'b1;

    // Control register fields
    reg slow_stop_q;
    reg slow_stop_d;
    reg periph_stop_q;
    reg periph_stop_d;
    reg fast_stop_q;
    reg fast_stop_d;
    reg source_sel_q;
    reg source_sel_d;
    reg [1:0] prescale_q;
    reg [1:0] prescale_d;

    // Switch sequencer
    reg state_q;
    reg state_d;
    reg active_d;

    // Gate enables next values
    reg slow_en_d;
    reg fast_en_d;
    reg periph_en_d;

    // Bus decode
    wire wr_ctrl;
    wire rd_ctrl;
    wire rd_status;
    wire slow_mode;
    reg [7:0] rdata_d;

    // Divider links
    wire src_tick;
    wire div_wrap;
    wire [1:0] applied_ratio;

    // Address decode of the single control register and the status view
    assign wr_ctrl = wr_i & (addr_i == `CLK_CTRL_ADDR);
    assign rd_ctrl = rd_i & (addr_i == `CLK_CTRL_ADDR);
    assign rd_status = rd_i & (addr_i == `CLK_STATUS_ADDR);

    // Slow mode means both the chosen and the running source are slow
    assign slow_mode = ~source_sel_q & ~active_source_o;

    // Next values of the control fields on a software write
    always @*
    begin
        slow_stop_d = slow_stop_q;
        periph_stop_d = periph_stop_q;
        fast_stop_d = fast_stop_q;
        source_sel_d = source_sel_q;
        prescale_d = prescale_q;
        if (wr_ctrl)
        begin
            slow_stop_d = wdata_i[`SLOW_STOP_BIT];
            periph_stop_d = wdata_i[`PERIPH_STOP_BIT];
            prescale_d = wdata_i[`PRESCALE_HI:`PRESCALE_LO];
            if (slow_mode)
            begin
                fast_stop_d = wdata_i[`FAST_STOP_BIT];
            end
            if (!fast_stop_q)
            begin
                source_sel_d = wdata_i[`SOURCE_SEL_BIT];
            end
        end
    end

    // Control register storage with its documented reset values
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            slow_stop_q <= `SLOW_STOP_RST;
            periph_stop_q <= `PERIPH_STOP_RST;
            fast_stop_q <= `FAST_STOP_RST;
            source_sel_q <= `SOURCE_SEL_RST;
            prescale_q <= `PRESCALE_RST;
        end
        else if (ce_i)
        begin
            slow_stop_q <= slow_stop_d;
            periph_stop_q <= periph_stop_d;
            fast_stop_q <= fast_stop_d;
            source_sel_q <= source_sel_d;
            prescale_q <= prescale_d;
        end
    end

    // Oscillator and peripheral gate requests
    always @*
    begin
        slow_en_d = ~(stop_mode_i & slow_stop_q);
        fast_en_d = ~(fast_stop_q & (~active_source_o | idle_mode_i));
        periph_en_d = ~(idle_mode_i & periph_stop_q);
    end

    // Registered gate enables
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            slow_osc_en_o <= 1'b1;
            fast_osc_en_o <= 1'b1;
            periph_clk_en_o <= 1'b1;
        end
        else if (ce_i)
        begin
            slow_osc_en_o <= slow_en_d;
            fast_osc_en_o <= fast_en_d;
            periph_clk_en_o <= periph_en_d;
        end
    end

    // Ticks of the running source count only while its oscillator runs
    assign src_tick = active_source_o ? (fast_tick_i & fast_osc_en_o)
                                      : (slow_tick_i & slow_osc_en_o);

    // Source switch sequencer: a new source takes over at a period edge
    always @*
    begin
        state_d = state_q;
        active_d = active_source_o;
        case (state_q)
            ST_RUN:
            begin
                if (source_sel_q != active_source_o)
                begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN:
            begin
                if (source_sel_q == active_source_o)
                begin
                    state_d = ST_RUN;
                end
                else if (div_wrap)
                begin
                    active_d = source_sel_q;
                    state_d = ST_RUN;
                end
            end
            default:
            begin
                state_d = ST_RUN;
            end
        endcase
    end

    // Sequencer state and running source
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q <= ST_RUN;
            active_source_o <= `SOURCE_SEL_RST;
        end
        else if (ce_i)
        begin
            state_q <= state_d;
            active_source_o <= active_d;
        end
    end

    prescale_divider #(
        .CNT_W(CNT_W)
    ) u_divider (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .src_tick_i(src_tick),
        .ratio_i(prescale_q),
        .wrap_o(div_wrap),
        .tick_o(sys_tick_o),
        .ratio_o(applied_ratio)
    );

    // Processor halts in Idle and Stop; peripherals follow their gate
    assign cpu_tick_o = sys_tick_o & ~idle_mode_i & ~stop_mode_i;
    assign periph_tick_o = sys_tick_o & periph_clk_en_o;

    // Read data mux; unmapped addresses and idle cycles give zero
    always @*
    begin
        rdata_d = 8'h00;
        if (rd_ctrl)
        begin
            rdata_d[`SLOW_STOP_BIT] = slow_stop_q;
            rdata_d[`PERIPH_STOP_BIT] = periph_stop_q;
            rdata_d[`FAST_STOP_BIT] = fast_stop_q;
            rdata_d[`SOURCE_SEL_BIT] = source_sel_q;
            rdata_d[`PRESCALE_HI:`PRESCALE_LO] = prescale_q;
        end
        else if (rd_status)
        begin
            rdata_d[7] = state_q;
            rdata_d[6] = periph_clk_en_o;
            rdata_d[5] = slow_osc_en_o;
            rdata_d[4] = fast_osc_en_o;
            rdata_d[2] = active_source_o;
            rdata_d[1:0] = applied_ratio;
        end
    end

    // Read data stands for the one cycle after the strobe
    always @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_o <= 8'h00;
        end
        else if (ce_i)
        begin
            rdata_o <= rdata_d;
        end
    end

endmodule // system_clock_select_gating

`default_nettype wire

// file: clock_control_properties.sv
// Port checker for the clock control block
`timescale 1ns/1ps
`default_nettype none
module clock_control_checker (
    input wire clk_i,
    input wire reset_n_i,
    input wire ce_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire stop_mode_i,
    input wire idle_mode_i,
    input wire slow_tick_i,
    input wire fast_tick_i,
    input wire slow_osc_en_o,
    input wire fast_osc_en_o,
    input wire periph_clk_en_o,
    input wire sys_tick_o,
    input wire periph_tick_o,
    input wire active_source_o
);
    logic src;
    logic [4:0] cnt_q;
    logic [4:0] cnt_d;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    // Source ticks seen since the last system tick
    assign src = ce_i & (active_source_o ? fast_tick_i & fast_osc_en_o
                                         : slow_tick_i & slow_osc_en_o);
    assign cnt_d = sys_tick_o ? {4'h0, src} : cnt_q + {4'h0, src};
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            cnt_q <= 5'h00;
        else
            cnt_q <= cnt_d;
    end

    read_idle_a: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    slow_run_a: assert property (ce_i && !stop_mode_i |=> slow_osc_en_o)
        else $error("slow source stopped outside stop mode");
    periph_run_a: assert property (ce_i && !idle_mode_i |=> periph_clk_en_o)
        else $error("peripheral clock stopped outside idle mode");
    periph_tick_a: assert property (periph_tick_o == (sys_tick_o && periph_clk_en_o))
        else $error("peripheral tick does not follow its gate");
    fast_live_a: assert property (active_source_o |-> fast_osc_en_o)
        else $error("fast source selected while stopped");
    tick_cause_a: assert property (sys_tick_o && $past(ce_i) |-> $past(src))
        else $error("system tick without a source tick");
    ratio_bound_a: assert property (cnt_q <= 5'h10)
        else $error("system tick period beyond sixteen ticks");
    reset_src_a: assert property ($rose(reset_n_i) |-> !active_source_o && !sys_tick_o)
        else $error("reset did not select the slow source");
endmodule // clock_control_checker

bind system_clock_select_gating clock_control_checker chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .stop_mode_i(stop_mode_i), .idle_mode_i(idle_mode_i),
    .slow_tick_i(slow_tick_i), .fast_tick_i(fast_tick_i),
    .slow_osc_en_o(slow_osc_en_o), .fast_osc_en_o(fast_osc_en_o),
    .periph_clk_en_o(periph_clk_en_o), .sys_tick_o(sys_tick_o),
    .periph_tick_o(periph_tick_o), .active_source_o(active_source_o)
);
`default_nettype wire

// file: system_clock_select_gating_bench.sv
// Testbench for the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "clock_control_map.vh"
module system_clock_select_gating_bench;
    logic clk_i, reset_n_i, wr_i, rd_i, stop_mode_i, idle_mode_i, ce_i;
    logic slow_tick_i = 1'b0;
    logic [7:0] addr_i, wdata_i;
    wire [7:0] rdata_o;
    wire slow_osc_en_o, fast_osc_en_o, periph_clk_en_o, sys_tick_o;
    wire cpu_tick_o, periph_tick_o, active_source_o;
    // Ticks and gate enables seen together
    wire [7:0] gate_view = {2'h0, sys_tick_o, cpu_tick_o, periph_tick_o,
                            fast_osc_en_o, periph_clk_en_o, slow_osc_en_o};
    integer errors = 0;
    integer total_checks = 0;
    integer k;

    system_clock_select_gating dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .stop_mode_i(stop_mode_i),
        .idle_mode_i(idle_mode_i), .slow_tick_i(slow_tick_i),
        .fast_tick_i(1'b1), .slow_osc_en_o(slow_osc_en_o),
        .fast_osc_en_o(fast_osc_en_o), .periph_clk_en_o(periph_clk_en_o),
        .sys_tick_o(sys_tick_o), .cpu_tick_o(cpu_tick_o),
        .periph_tick_o(periph_tick_o), .active_source_o(active_source_o)
    );

    // Bus clock and a slow source at half its rate
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) slow_tick_i <= ~slow_tick_i;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    // Cycles between two system ticks once the ratio has settled
    task meas(input integer n);
        repeat (40) @(posedge clk_i);
        #1;
        while (sys_tick_o !== 1'b1) @(posedge clk_i) #1;
        k = 0;
        do
        begin
            @(posedge clk_i) #1;
            k++;
        end
        while (sys_tick_o !== 1'b1 && k < 40);
        chk(k[7:0], n[7:0]);
    endtask

    task test_done;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial
    begin
        #100000;
        errors++;
        test_done;
    end

    initial
    begin
        {wr_i, rd_i, stop_mode_i, idle_mode_i} = 4'h0;
        ce_i = 1'b1;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        reset_n_i = 1'b0;
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        wr(8'h10, 8'hff);
        rd(`CLK_CTRL_ADDR, 8'h23);
        rd(`CLK_STATUS_ADDR, 8'h73);
        rd(8'h10, 8'h00);
        meas(2);
        $display("test reset done");
        wr(`CLK_CTRL_ADDR, 8'hfb);
        rd(`CLK_CTRL_ADDR, 8'h3b);
        chk({7'h00, fast_osc_en_o}, 8'h00);
        wr(`CLK_CTRL_ADDR, 8'h3f);
        rd(`CLK_CTRL_ADDR, 8'h3b);
        wr(`CLK_CTRL_ADDR, 8'h33);
        wr(`CLK_CTRL_ADDR, 8'h37);
        repeat (40) @(posedge clk_i);
        #1 chk({7'h00, active_source_o}, 8'h01);
        rd(`CLK_STATUS_ADDR, 8'h77);
        wr(`CLK_CTRL_ADDR, 8'h3f);
        rd(`CLK_CTRL_ADDR, 8'h37);
        $display("test access done");
        for (int c = 0; c < 4; c++)
        begin
            wr(`CLK_CTRL_ADDR, 8'h34 | c[7:0]);
            meas(c == 0 ? 16 : 4 >> (c - 1));
        end
        $display("test ratio done");
        // A write while the clock enable is low must not land
        @(posedge clk_i);
        ce_i <= 1'b0;
        wr(`CLK_CTRL_ADDR, 8'h04);
        ce_i <= 1'b1;
        rd(`CLK_CTRL_ADDR, 8'h37);
        $display("test freeze done");
        @(posedge clk_i);
        idle_mode_i <= 1'b1;
        stop_mode_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1 chk(gate_view, 8'h24);
        wr(`CLK_CTRL_ADDR, 8'h07);
        repeat (2) @(posedge clk_i);
        #1 chk(gate_view, 8'h2f);
        $display("test gating done");
        test_done;
    end
endmodule // system_clock_select_gating_bench
`default_nettype wire
